/* File: pkg/trx_regs_pkg.sv */
// Register map, field layout and reset values of the transceiver SPI register slice
package trx_regs_pkg;
    localparam int ADDR_W     = 6;
    localparam int WORD_W     = 16;
    localparam int LEN_W      = 7;
    localparam int CNT_W      = 4;
    localparam int CMD_RD_BIT = 7;

    localparam logic [5:0] A_SOFT_RST = 6'h00;
    localparam logic [5:0] A_RX_PORT  = 6'h01;
    localparam logic [5:0] A_TX_PORT  = 6'h02;
    localparam logic [5:0] A_TX_CTRL  = 6'h03;
    localparam logic [5:0] A_CCA      = 6'h04;
    localparam logic [5:0] A_RX_STAT  = 6'h2D;
    localparam logic [5:0] A_BER      = 6'h30;
    localparam logic [5:0] A_PSM      = 6'h31;

    localparam int TXC_SEL_BIT = 15;
    localparam int THR_LSB     = 8;
    localparam int STAT_E_LSB  = 8;
    localparam int BER_BIT     = 15;
    localparam int PSM_W       = 3;

    localparam logic [3:0] HDR_LAST  = 4'h7;
    localparam logic [3:0] WORD_LAST = 4'hF;
    localparam logic [7:0] THR_RST   = 8'h00;
    localparam logic [7:0] OFS_RST   = 8'h8D;
    localparam logic [6:0] LEN_RST   = 7'h00;
    localparam logic [6:0] FCS_BYTES = 7'h02;
    localparam logic [2:0] PIN_RST   = 3'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HDR  = 3'b010,
        ST_DATA = 3'b100
    } spi_state_e;
endpackage : trx_regs_pkg

/* File: logic/pin_sync.sv */
// Two-flop synchroniser for pins that come from outside the clock domain
module pin_sync #(
    parameter int           N       = 1,
    parameter logic [N-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    // Pins
    input  wire logic [N-1:0] i_async,
    output logic      [N-1:0] o_sync
);
    typedef struct packed {
        logic [N-1:0] meta;
        logic [N-1:0] sync;
    } sync_s;

    sync_s q;
    sync_s d;

    // The first stage feeds only the second stage
    always_comb begin
        d.meta = i_async;
        d.sync = q.meta;
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            q <= '{meta: RST_VAL, sync: RST_VAL};
        end else begin
            q <= d;
        end
    end

    assign o_sync = q.sync;
endmodule : pin_sync

/* File: logic/two_entry_fifo.sv */
// Small word buffer with valid and ready on both sides
module two_entry_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    // Filling side
    input  wire logic         i_wr_valid,
    output logic              o_wr_ready,
    input  wire logic [W-1:0] i_wr_data,
    // Draining side
    output logic              o_rd_valid,
    input  wire logic         i_rd_ready,
    output logic      [W-1:0] o_rd_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [PW:0]             cnt;
    } fifo_s;

    fifo_s q;
    fifo_s d;
    logic  push;
    logic  pop;

    assign o_wr_ready = (q.cnt != (PW+1)'(DEPTH));
    assign o_rd_valid = (q.cnt != '0);
    assign o_rd_data  = q.mem[q.rp];

    always_comb begin
        d    = q;
        push = i_wr_valid && o_wr_ready;
        pop  = o_rd_valid && i_rd_ready;
        if (push) begin
            d.mem[q.wp] = i_wr_data;
            d.wp        = (q.wp == PW'(DEPTH-1)) ? '0 : q.wp + PW'(1);
        end
        if (pop) begin
            d.rp = (q.rp == PW'(DEPTH-1)) ? '0 : q.rp + PW'(1);
        end
        if (push && !pop) begin
            d.cnt = q.cnt + (PW+1)'(1);
        end else if (pop && !push) begin
            d.cnt = q.cnt - (PW+1)'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : two_entry_fifo

/* File: logic/trx_spi_regs.sv */
// SPI register slice: soft reset, packet data ports, transmit control, energy threshold
// How it works
// - Any write to address 00 starts reset
// - Reset restores register defaults, keeps packet RAMs
// - Reset holds while chip select stays low
// - Reading address 00 does nothing
// - Received length latched in status bits 6-0
// - Stream receive word sets flag and interrupt
// - Reading port 01 clears receive word flag
// - Receive port content after reset undefined
// - Two transmit RAMs, only selected one used
// - Stream transmit need sets flag, write clears
// - Control bit 15 picks transmit RAM2
// - Length counts payload bytes plus two
// - Threshold bits 15-8, reset zero
// - Half offset added to energy, stored
// - Offset resets to 8D, 9B suggested
// - Interrupt only when enabled, read clears; transmit interrupt cleared by port 02 write instead
// - Mode inputs pick stream or packet
module trx_spi_regs
    import trx_regs_pkg::*;
#(
    parameter int RAM_WORDS = 64
) (
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    // SPI pins
    input  wire logic              i_sclk,
    input  wire logic              i_csn,
    input  wire logic              i_mosi,
    output logic                   o_miso,
    output logic                   o_miso_oe,
    // Mode and interrupt enables
    input  wire logic              i_tx_stream_mode,
    input  wire logic              i_rx_stream_mode,
    input  wire logic              i_rx_irq_en,
    input  wire logic              i_tx_irq_en,
    // Receive words from the modem
    input  wire logic              i_rx_valid,
    output logic                   o_rx_ready,
    input  wire logic [WORD_W-1:0] i_rx_data,
    input  wire logic              i_rx_done,
    input  wire logic [LEN_W-1:0]  i_rx_len,
    // Energy measurement
    input  wire logic              i_energy_valid,
    input  wire logic [7:0]        i_energy_raw,
    // Transmit words to the modem
    input  wire logic              i_tx_start,
    output logic                   o_tx_valid,
    input  wire logic              i_tx_ready,
    output logic      [WORD_W-1:0] o_tx_data,
    // Status and control outputs
    output logic                   o_soft_reset,
    output logic                   o_rx_word_req,
    output logic                   o_tx_word_req,
    output logic                   o_irq,
    output logic                   o_tx_buffer_choice,
    output logic      [LEN_W-1:0]  o_tx_len,
    output logic      [7:0]        o_channel_busy_threshold,
    output logic                   o_ber_en,
    output logic      [PSM_W-1:0]  o_power_state_test_sel
);
    localparam int PTR_W = $clog2(RAM_WORDS);

    typedef struct packed {
        spi_state_e        st;
        logic              sclk_q;
        logic [CNT_W-1:0]  bit_cnt;
        logic [WORD_W-1:0] sh;
        logic [WORD_W-1:0] out_sh;
        logic              rw;
        logic [ADDR_W-1:0] addr;
        logic              miso;
        logic              miso_oe;
        logic              soft_rst;
        logic              tx_sel;
        logic [LEN_W-1:0]  tx_len;
        logic [7:0]        thr;
        logic [7:0]        ofs;
        logic              ber;
        logic [PSM_W-1:0]  psm;
        logic [LEN_W-1:0]  rx_len;
        logic [7:0]        cca_final;
        logic [WORD_W-1:0] rx_hold;
        logic              rx_flag;
        logic              tx_flag;
        logic [PTR_W-1:0]  rx_wr_ptr;
        logic [PTR_W-1:0]  rx_rd_ptr;
        logic [PTR_W-1:0]  tx_wr_ptr;
        logic [PTR_W-1:0]  tx_rd_ptr;
        logic [LEN_W-1:0]  tx_rem;
        logic [WORD_W-1:0] tx_out;
        logic              tx_out_v;
    } regs_s;

    localparam regs_s RST_Q = '{st: ST_IDLE, ofs: OFS_RST, thr: THR_RST, default: '0};

    regs_s q;
    regs_s d;

    // Packet RAMs are kept apart from the state so no reset ever touches them
    logic [WORD_W-1:0] rx_ram [RAM_WORDS];
    logic [WORD_W-1:0] tx_ram [2][RAM_WORDS];

    logic              sclk_s;
    logic              csn_s;
    logic              mosi_s;
    logic              buf_valid;
    logic              buf_rd_ready;
    logic [WORD_W-1:0] buf_data;
    logic              sclk_rise;
    logic              sclk_fall;
    logic              hdr_done;
    logic              word_done;
    logic              rd_load;
    logic              rx_pop;
    logic              rx_take;
    logic              rx_we;
    logic              tx_we;
    logic              tx_wr_hit;
    logic              tx_take;
    logic [7:0]        cmd;
    logic [WORD_W-1:0] word;
    logic [ADDR_W-1:0] ra;
    logic [WORD_W-1:0] rv;

    pin_sync #(
        .N       (3),
        .RST_VAL (PIN_RST)
    ) u_pins (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_async ({i_mosi, i_csn, i_sclk}),
        .o_sync  ({mosi_s, csn_s, sclk_s})
    );

    // A stalled reader or a busy stream port backs up into the modem here
    two_entry_fifo #(
        .W          (WORD_W),
        .DEPTH      (2)
    ) u_rx_buf (
        .i_clk      (i_clk),
        .i_rstn     (i_rstn),
        .i_wr_valid (i_rx_valid),
        .o_wr_ready (o_rx_ready),
        .i_wr_data  (i_rx_data),
        .o_rd_valid (buf_valid),
        .i_rd_ready (buf_rd_ready),
        .o_rd_data  (buf_data)
    );

    always_comb begin
        d         = q;
        hdr_done  = 1'b0;
        word_done = 1'b0;
        rd_load   = 1'b0;
        rx_pop    = 1'b0;
        rx_we     = 1'b0;
        tx_we     = 1'b0;
        tx_wr_hit = 1'b0;
        rv        = '0;
        cmd       = {q.sh[6:0], mosi_s};
        word      = {q.sh[14:0], mosi_s};
        sclk_rise = sclk_s && !q.sclk_q;
        sclk_fall = !sclk_s && q.sclk_q;
        d.sclk_q  = sclk_s;
        tx_take   = q.tx_out_v && i_tx_ready;

        // Transmit output stage
        if (tx_take) begin
            d.tx_out_v = 1'b0;
        end
        if (i_tx_start && !i_tx_stream_mode) begin
            d.tx_rd_ptr = '0;
            d.tx_rem    = (q.tx_len < FCS_BYTES) ? '0
                        : (q.tx_len - FCS_BYTES + 7'h01) >> 1;
        end else if (!i_tx_stream_mode && q.tx_rem != '0 && (!q.tx_out_v || tx_take)) begin
            d.tx_out    = tx_ram[q.tx_sel][q.tx_rd_ptr];
            d.tx_out_v  = 1'b1;
            d.tx_rem    = q.tx_rem - 7'h01;
            d.tx_rd_ptr = q.tx_rd_ptr + PTR_W'(1);
        end

        // SPI frame: header byte, then 16-bit words on the same address
        if (csn_s) begin
            d.st       = ST_IDLE;
            d.soft_rst = 1'b0;
            d.miso_oe  = 1'b0;
        end else begin
            case (q.st)
                ST_IDLE: begin
                    d.st        = ST_HDR;
                    d.bit_cnt   = '0;
                    d.rx_rd_ptr = '0;
                    d.tx_wr_ptr = '0;
                end
                ST_HDR: begin
                    if (sclk_rise) begin
                        d.sh      = word;
                        d.bit_cnt = q.bit_cnt + 4'h1;
                        if (q.bit_cnt == HDR_LAST) begin
                            hdr_done  = 1'b1;
                            d.st      = ST_DATA;
                            d.bit_cnt = '0;
                            d.rw      = cmd[CMD_RD_BIT];
                            d.addr    = cmd[ADDR_W-1:0];
                            d.miso_oe = cmd[CMD_RD_BIT];
                            rd_load   = cmd[CMD_RD_BIT];
                            if (!cmd[CMD_RD_BIT] && cmd[ADDR_W-1:0] == A_SOFT_RST) begin
                                d.soft_rst = 1'b1;
                            end
                        end
                    end
                end
                ST_DATA: begin
                    if (sclk_rise) begin
                        d.sh      = word;
                        d.bit_cnt = q.bit_cnt + 4'h1;
                        if (q.bit_cnt == WORD_LAST) begin
                            word_done = 1'b1;
                            rd_load   = q.rw;
                        end
                    end
                    if (sclk_fall && q.rw) begin
                        d.miso   = q.out_sh[WORD_W-1];
                        d.out_sh = {q.out_sh[WORD_W-2:0], 1'b0};
                    end
                end
                default: begin
                    d.st = ST_IDLE;
                end
            endcase
        end

        // Register writes; data written to address 00 is ignored
        if (word_done && !q.rw) begin
            if (q.addr == A_TX_PORT) begin
                if (i_tx_stream_mode) begin
                    d.tx_out   = word;
                    d.tx_out_v = 1'b1;
                    tx_wr_hit  = 1'b1;
                end else begin
                    tx_we       = 1'b1;
                    d.tx_wr_ptr = q.tx_wr_ptr + PTR_W'(1);
                end
            end else if (q.addr == A_TX_CTRL) begin
                d.tx_sel = word[TXC_SEL_BIT];
                d.tx_len = word[LEN_W-1:0];
            end else if (q.addr == A_CCA) begin
                d.thr = word[THR_LSB +: 8];
                d.ofs = word[7:0];
            end else if (q.addr == A_BER) begin
                d.ber = word[BER_BIT];
            end else if (q.addr == A_PSM) begin
                d.psm = word[PSM_W-1:0];
            end
        end

        // Read data for the next word; a read of address 00 returns zero
        ra = hdr_done ? cmd[ADDR_W-1:0] : q.addr;
        if (ra == A_RX_PORT) begin
            rv = i_rx_stream_mode ? q.rx_hold : rx_ram[q.rx_rd_ptr];
        end else if (ra == A_TX_CTRL) begin
            rv[TXC_SEL_BIT] = q.tx_sel;
            rv[LEN_W-1:0]   = q.tx_len;
        end else if (ra == A_CCA) begin
            rv = {q.thr, q.ofs};
        end else if (ra == A_RX_STAT) begin
            rv[STAT_E_LSB +: 8] = q.cca_final;
            rv[LEN_W-1:0]       = q.rx_len;
        end else if (ra == A_BER) begin
            rv[BER_BIT] = q.ber;
        end else if (ra == A_PSM) begin
            rv[PSM_W-1:0] = q.psm;
        end
        if (rd_load) begin
            d.out_sh = rv;
            if (ra == A_RX_PORT) begin
                if (i_rx_stream_mode) begin
                    // One word per read frame; a word-end pop would drop an unread word
                    rx_pop = hdr_done;
                end else begin
                    d.rx_rd_ptr = q.rx_rd_ptr + PTR_W'(1);
                end
            end
        end

        // Receive side: packet words go to RAM, stream words to the port
        buf_rd_ready = i_rx_stream_mode ? (!q.rx_flag || rx_pop) : 1'b1;
        rx_take      = buf_valid && buf_rd_ready;
        if (rx_take) begin
            if (i_rx_stream_mode) begin
                d.rx_hold = buf_data;
            end else begin
                rx_we       = 1'b1;
                d.rx_wr_ptr = q.rx_wr_ptr + PTR_W'(1);
            end
        end
        if (i_rx_done && !i_rx_stream_mode) begin
            d.rx_len    = i_rx_len;
            d.rx_wr_ptr = '0;
        end
        if (i_energy_valid) begin
            d.cca_final = i_energy_raw + {1'b0, q.ofs[7:1]};
        end

        // Set wins over clear on both word flags
        if (rx_pop) begin
            d.rx_flag = 1'b0;
        end
        if (rx_take && i_rx_stream_mode) begin
            d.rx_flag = 1'b1;
        end
        if (tx_wr_hit) begin
            d.tx_flag = 1'b0;
        end
        if (i_tx_stream_mode && (i_tx_start || tx_take)) begin
            d.tx_flag = 1'b1;
        end

        // Held soft reset: registers at defaults, transmit output to the modem forced idle
        if (q.soft_rst) begin
            d.tx_sel    = 1'b0;
            d.tx_len    = LEN_RST;
            d.thr       = THR_RST;
            d.ofs       = OFS_RST;
            d.ber       = 1'b0;
            d.psm       = '0;
            d.rx_len    = LEN_RST;
            d.cca_final = '0;
            d.rx_flag   = 1'b0;
            d.tx_flag   = 1'b0;
            d.tx_rem    = '0;
            d.tx_out_v  = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            q <= RST_Q;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (rx_we) begin
            rx_ram[q.rx_wr_ptr] <= buf_data;
        end
        if (tx_we) begin
            tx_ram[q.tx_sel][q.tx_wr_ptr] <= word;
        end
    end

    assign o_miso                   = q.miso;
    assign o_miso_oe                = q.miso_oe;
    assign o_tx_valid               = q.tx_out_v;
    assign o_tx_data                = q.tx_out;
    assign o_soft_reset             = q.soft_rst;
    assign o_rx_word_req            = q.rx_flag;
    assign o_tx_word_req            = q.tx_flag;
    assign o_irq                    = (q.rx_flag && i_rx_irq_en) || (q.tx_flag && i_tx_irq_en);
    assign o_tx_buffer_choice       = q.tx_sel;
    assign o_tx_len                 = q.tx_len;
    assign o_channel_busy_threshold = q.thr;
    assign o_ber_en                 = q.ber;
    assign o_power_state_test_sel   = q.psm;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_reset_write;
        hdr_done && !cmd[CMD_RD_BIT] && cmd[ADDR_W-1:0] == A_SOFT_RST;
    endsequence

    sequence s_reset_read;
        hdr_done && cmd[CMD_RD_BIT] && cmd[ADDR_W-1:0] == A_SOFT_RST;
    endsequence

    a_reset_trigger: assert property (s_reset_write |=> q.soft_rst ##1 q.thr == THR_RST)
        else $error("soft reset not taken on write to 00");
    a_reset_defaults: assert property (q.soft_rst |=> q.ofs == OFS_RST && !q.tx_sel && !q.ber)
        else $error("register not at default during soft reset");
    a_reset_hold: assert property (q.soft_rst && !csn_s |=> q.soft_rst)
        else $error("soft reset dropped while chip select low");
    a_reset_release: assert property (csn_s |=> !q.soft_rst)
        else $error("soft reset still held after chip select high");
    a_read_no_effect: assert property (s_reset_read and !q.soft_rst |=> !q.soft_rst)
        else $error("read of 00 caused a reset");
    a_rx_len_latch: assert property (i_rx_done && !i_rx_stream_mode && !q.soft_rst
        |=> q.rx_len == $past(i_rx_len))
        else $error("received length not latched");
    a_rx_flag_set: assert property (rx_take && i_rx_stream_mode && !q.soft_rst
        |=> q.rx_flag && (o_irq || !i_rx_irq_en))
        else $error("stream receive word did not raise flag");
    a_rx_flag_clear: assert property (rx_pop && !rx_take && !q.soft_rst |=> !q.rx_flag)
        else $error("receive word flag not cleared by read");
    a_tx_flag_clear: assert property (tx_wr_hit && !tx_take && !i_tx_start |=> !q.tx_flag)
        else $error("transmit word flag not cleared by write");
    a_tx_ram_select: assert property (tx_we |=> tx_ram[$past(q.tx_sel)][$past(q.tx_wr_ptr)]
        == $past(word))
        else $error("payload not stored in selected transmit RAM");
    a_tx_len_words: assert property (i_tx_start && !i_tx_stream_mode && !q.soft_rst
        && q.tx_len >= FCS_BYTES
        |=> 8'(2) * 8'(q.tx_rem) + 8'(FCS_BYTES) >= 8'($past(q.tx_len)))
        else $error("transmit word count short of length");
    a_cca_sum: assert property (i_energy_valid && !q.soft_rst
        |=> q.cca_final == 8'($past(i_energy_raw) + ($past(q.ofs) >> 1)))
        else $error("energy result not offset by half compensation");
endmodule : trx_spi_regs

/* File: sim/spi_host_model.sv */
// Host side SPI master model: mode 0, MSB first, bursts on one address
module spi_host_model (
    // Clock
    input  wire logic i_clk,
    // SPI pins
    output logic      o_sclk,
    output logic      o_csn,
    output logic      o_mosi,
    input  wire logic i_miso
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_sclk = 1'b0;
        o_csn  = 1'b1;
        o_mosi = 1'b0;
    end
    // Half link period is four system clocks, so the link runs at 160 ns
    task automatic half();
        repeat (4) @(posedge i_clk);
        #1;
    endtask : half
    task automatic bit1(input logic b, output logic r);
        o_mosi = b;
        half();
        r      = i_miso;
        o_sclk = 1'b1;
        half();
        o_sclk = 1'b0;
    endtask : bit1
    // Leaves chip select low when keep is set, so a held reset can be seen
    task automatic frame(input logic [7:0] h, input logic [15:0] w[$],
                         output logic [15:0] r[$], input logic keep);
        logic        b;
        logic [15:0] v;
        r     = {};
        o_csn = 1'b0;
        half();
        for (int i = 7; i >= 0; i--) bit1(h[i], b);
        foreach (w[k]) begin
            for (int i = 15; i >= 0; i--) bit1(w[k][i], v[i]);
            r.push_back(v);
        end
        if (!keep) fin();
    endtask : frame
    // Released data line must not keep showing the last bit
    task automatic fin();
        half();
        o_csn  = 1'b1;
        o_mosi = ~o_mosi;
        repeat (2) half();
    endtask : fin
endmodule : spi_host_model

/* File: sim/test_trx_spi_regs.sv */
// Self-checking bench for the transceiver SPI register slice
module test_trx_spi_regs
    import trx_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk, i_rstn, i_sclk, i_csn, i_mosi, o_miso, o_miso_oe, miso_pin;
    logic i_tx_stream_mode, i_rx_stream_mode, i_rx_irq_en, i_tx_irq_en;
    logic i_rx_valid, o_rx_ready, i_rx_done, i_energy_valid, i_tx_start;
    logic o_tx_valid, i_tx_ready, o_soft_reset, o_rx_word_req, o_tx_word_req;
    logic o_irq, o_tx_buffer_choice, o_ber_en;
    logic [15:0] i_rx_data, o_tx_data, q[$];
    logic [6:0]  i_rx_len, o_tx_len;
    logic [7:0]  i_energy_raw, o_channel_busy_threshold;
    logic [2:0]  o_power_state_test_sel;
    int          mismatches, n_compared;
    assign miso_pin = o_miso_oe ? o_miso : ~o_miso;
    trx_spi_regs trx_spi_regs_inst (.i_clk, .i_rstn, .i_sclk, .i_csn, .i_mosi,
        .o_miso, .o_miso_oe, .i_tx_stream_mode, .i_rx_stream_mode, .i_rx_irq_en,
        .i_tx_irq_en, .i_rx_valid, .o_rx_ready, .i_rx_data, .i_rx_done, .i_rx_len,
        .i_energy_valid, .i_energy_raw, .i_tx_start, .o_tx_valid, .i_tx_ready,
        .o_tx_data, .o_soft_reset, .o_rx_word_req, .o_tx_word_req, .o_irq,
        .o_tx_buffer_choice, .o_tx_len, .o_channel_busy_threshold, .o_ber_en,
        .o_power_state_test_sel);
    spi_host_model host_inst (.i_clk, .o_sclk(i_sclk), .o_csn(i_csn),
        .o_mosi(i_mosi), .i_miso(miso_pin));
    always #10 i_clk = ~i_clk;
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        host_inst.frame({2'b00, a}, '{d}, q, 1'b0);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        host_inst.frame({2'b10, a}, '{16'h0000}, q, 1'b0);
        chk(q[0], e);
    endtask : rd
    // Modem takes each word one edge after raising ready, idling one cycle between words
    task automatic txpkt(input logic [15:0] w0, input logic [15:0] w1);
        i_tx_start = 1'b1;
        tick(1);
        i_tx_start = 1'b0;
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 20 && o_tx_valid !== 1'b1; i++) tick(1);
            chk(o_tx_data, k ? w1 : w0);
            i_tx_ready = 1'b1;
            tick(1);
            i_tx_ready = 1'b0;
            tick(1);
        end
        tick(2);
        chk({15'h0, o_tx_valid}, 16'h0000);
    endtask : txpkt
    task automatic push(input logic [15:0] d);
        i_rx_data  = d;
        i_rx_valid = 1'b1;
        for (int i = 0; i < 50 && o_rx_ready !== 1'b1; i++) tick(1);
        tick(1);
        i_rx_valid = 1'b0;
        tick(1);
    endtask : push
    task automatic close_out();
        $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    initial begin
        #400us;
        mismatches++;
        close_out();
    end
    initial begin
        {i_clk, i_rstn, i_tx_stream_mode, i_rx_stream_mode, i_rx_irq_en} = '0;
        {i_tx_irq_en, i_rx_valid, i_rx_done, i_energy_valid, i_tx_start} = '0;
        {i_tx_ready, i_rx_data, i_rx_len, i_energy_raw} = '0;
        tick(4);
        i_rstn = 1'b1;
        tick(3);
        rd(A_CCA, 16'h008D);
        rd(6'h3F, 16'h0000);
        wr(A_TX_CTRL, 16'hFF85);
        rd(A_TX_CTRL, 16'h8005);
        chk({o_tx_buffer_choice, 8'h00, o_tx_len}, 16'h8005);
        wr(A_CCA, 16'h1E9B);
        chk({o_channel_busy_threshold, 8'h00}, 16'h1E00);
        {i_energy_valid, i_energy_raw, i_rx_done, i_rx_len} = {9'h110, 8'hAA};
        tick(1);
        {i_energy_valid, i_rx_done} = '0;
        rd(A_RX_STAT, 16'h5D2A);
        wr(A_BER, 16'h8000);
        wr(A_PSM, 16'h0005);
        chk({o_ber_en, 12'h000, o_power_state_test_sel}, 16'h8005);
        host_inst.frame(8'h02, '{16'hA1B2, 16'hC3D4}, q, 1'b0);
        wr(A_TX_CTRL, 16'h0005);
        host_inst.frame(8'h02, '{16'h1111, 16'h2222}, q, 1'b0);
        txpkt(16'h1111, 16'h2222);
        host_inst.frame(8'h00, '{16'h5A5A}, q, 1'b1);
        chk({15'h0, o_soft_reset}, 16'h0001);
        chk({o_tx_buffer_choice, 8'h00, o_tx_len}, 16'h0000);
        host_inst.fin();
        chk({15'h0, o_soft_reset}, 16'h0000);
        rd(A_CCA, 16'h008D);
        rd(A_SOFT_RST, 16'h0000);
        chk({15'h0, o_soft_reset}, 16'h0000);
        wr(A_TX_CTRL, 16'h8005);
        txpkt(16'hA1B2, 16'hC3D4);
        push(16'h1234);
        push(16'h5678);
        tick(2);
        host_inst.frame(8'h81, '{16'h0000, 16'h0000}, q, 1'b0);
        chk(q[0], 16'h1234);
        chk(q[1], 16'h5678);
        {i_rx_stream_mode, i_rx_irq_en} = 2'b11;
        push(16'hC0DE);
        push(16'h0BAD);
        push(16'h0FEE);
        tick(3);
        chk({o_rx_word_req, o_irq, o_rx_ready}, 16'h0006);
        rd(A_RX_PORT, 16'hC0DE);
        rd(A_RX_PORT, 16'h0BAD);
        i_rx_irq_en = 1'b0;
        tick(3);
        chk({o_rx_word_req, o_irq}, 16'h0002);
        rd(A_RX_PORT, 16'h0FEE);
        chk({o_rx_word_req, o_irq}, 16'h0000);
        {i_rx_stream_mode, i_tx_stream_mode, i_tx_irq_en, i_tx_start} = 4'b0111;
        tick(1);
        i_tx_start = 1'b0;
        tick(2);
        chk({o_tx_word_req, o_irq}, 16'h0003);
        wr(A_TX_PORT, 16'hBEEF);
        chk({o_tx_valid, o_tx_word_req, o_irq}, 16'h0004);
        chk(o_tx_data, 16'hBEEF);
        i_tx_ready = 1'b1;
        tick(1);
        i_tx_ready = 1'b0;
        tick(2);
        chk({o_tx_valid, o_tx_word_req}, 16'h0001);
        close_out();
    end
endmodule : test_trx_spi_regs
